// ---- rtl/bph_defs.svh ----
// Timing counts, field positions and reset values of the host power handshake block
`ifndef BPH_DEFS_SVH
`define BPH_DEFS_SVH

`define BPH_CLK_PERIOD_NS   40
`define BPH_CLK_SETTLE_NS   2000
`define BPH_CLK_SETTLE_CYC  ((`BPH_CLK_SETTLE_NS + `BPH_CLK_PERIOD_NS - 1) / `BPH_CLK_PERIOD_NS)
`define BPH_INIT_NS         10000
`define BPH_INIT_CYC        ((`BPH_INIT_NS + `BPH_CLK_PERIOD_NS - 1) / `BPH_CLK_PERIOD_NS)

`define BPH_CNT_W           16
`define BPH_SYNC_W          4
`define BPH_SYNC_PWR        0
`define BPH_SYNC_WAKE       1
`define BPH_SYNC_FLOW       2
`define BPH_SYNC_LPC        3

`define BPH_RF_W            4
`define BPH_RF_TX           0
`define BPH_RF_RX           1
`define BPH_RF_PLL          2
`define BPH_RF_PA           3
`define BPH_RF_PD_ALL       4'hF

`endif

// ---- rtl/bph_lp_timer.sv ----
// Low-power interval timer counting rising edges of the synchronised low-power clock
`default_nettype none
`include "bph_defs.svh"
module bph_lp_timer
	import bph_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire logic     reset,
	input  wire logic     lpc_s,
	input  wire logic     load,
	input  wire logic     active,
	input  wire bph_cnt_t interval,
	output var  logic     expired
);
	logic     prev_r;
	logic     prev_nxt;
	logic     run_r;
	logic     run_nxt;
	bph_cnt_t cnt_r;
	bph_cnt_t cnt_nxt;
	logic     tick;

	always_comb begin
		tick     = lpc_s & ~prev_r;
		prev_nxt = lpc_s;
		run_nxt  = run_r;
		cnt_nxt  = cnt_r;
		if (load) begin
			run_nxt = 1'h1;
			cnt_nxt = interval;
		end else if (!active) begin
			run_nxt = 1'h0;
		end else if (run_r && tick && cnt_r != 16'h0000) begin
			cnt_nxt = cnt_r - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prev_r <= 1'h0;
			run_r  <= 1'h0;
			cnt_r  <= 16'h0000;
		end else begin
			prev_r <= prev_nxt;
			run_r  <= run_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	assign expired = run_r & (cnt_r == 16'h0000);
endmodule
`default_nettype wire

// ---- rtl/bph_pkg.sv ----
// Types shared by the host power handshake block
`default_nettype none
`include "bph_defs.svh"
package bph_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_CLK_SETTLE,
		ST_INIT,
		ST_LINK_WAIT,
		ST_AWAKE,
		ST_SLEEP,
		ST_LOWPOW
	} bph_state_e;
	typedef logic [`BPH_CNT_W-1:0]  bph_cnt_t;
	typedef logic [`BPH_RF_W-1:0]   bph_rf_t;
	typedef logic [`BPH_SYNC_W-1:0] bph_sync_t;
endpackage
`default_nettype wire

// ---- rtl/bph_sync.sv ----
// Two-stage synchroniser for the pin inputs
`default_nettype none
`include "bph_defs.svh"
module bph_sync
	import bph_pkg::*;
(
	input  wire logic      ref_clk,
	input  wire logic      reset,
	input  wire bph_sync_t pins,
	output var  bph_sync_t pins_s
);
	bph_sync_t meta_r;
	bph_sync_t meta_nxt;
	bph_sync_t sync_r;
	bph_sync_t sync_nxt;

	always_comb begin
		meta_nxt = pins;
		sync_nxt = meta_r;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign pins_s = sync_r;
endmodule
`default_nettype wire

// ---- rtl/bph_top.sv ----
// Power sequencer and out-of-band wake handshake of the radio controller
// Function
// - Power manager reacts to software requests and baseband packet events alike.
// - Wake handshake lines are used in UART mode when enabled.
// - Asserted device wake request wakes the device and blocks sleep.
// - Without device wake request, sleep only once sleep criteria hold.
// - Host wake output asserted while the device needs host attention.
// - Device wake input and host wake output polarity selectable.
// - Reference clock request high when radio or WLAN needs the clock.
// - Reference clock request rises after power enable if host clock used.
// - Device I/O other than the reference clock request enabled only after reset and clock settling time.
// - Device drives its flow ready low after host does and init ends.
// - Separate power-down controls for transmit, receive, PLL and amplifier.
// - RF sections switched on only within transmit and receive windows.
// - Low-power modes run on low-power clock, wake after programmed interval.
// - In shutdown all outputs tristated except the reference clock request while WLAN needs the clock; most inputs ignored.
// - Leaving shutdown is a fresh power-up with no retained state.
// - Power-on reset held while power enable low, released after rise.
`default_nettype none
`include "bph_defs.svh"
module bph_top
	import bph_pkg::*;
(
	input  wire logic     ref_clk,
	input  wire logic     reset,
	input  wire logic     radio_power_enable,
	input  wire logic     wake_input_pin,
	input  wire logic     uart_flow_ready_in_n,
	input  wire logic     low_power_clock,
	input  wire logic     wake_handshake_en,
	input  wire logic     dev_wake_active_high,
	input  wire logic     host_wake_active_high,
	input  wire logic     host_ref_clk_used,
	input  wire logic     wlan_clk_need,
	input  wire logic     sw_sleep_req,
	input  wire logic     sw_wake_req,
	input  wire logic     bb_sleep_req,
	input  wire logic     bb_wake_req,
	input  wire logic     sleep_criteria_met,
	input  wire logic     host_attention_need,
	input  wire logic     lp_mode_req,
	input  wire bph_cnt_t lp_interval,
	input  wire logic     tx_window,
	input  wire logic     rx_window,
	input  wire logic     sw_rf_off,
	output var  logic     wake_output_pin,
	output var  logic     wake_output_pin_oe,
	output var  logic     uart_flow_ready_out_n,
	output var  logic     uart_flow_ready_out_oe,
	output var  logic     ref_clk_request,
	output var  logic     ref_clk_request_oe,
	output var  logic     rf_tx_pd,
	output var  logic     rf_rx_pd,
	output var  logic     rf_pll_pd,
	output var  logic     rf_pa_pd,
	output var  logic     por_active,
	output var  logic     lp_clock_select,
	output var  logic     core_awake
);
	function automatic logic pol_map(input logic level, input logic act_high);
		pol_map = act_high ? level : ~level;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and low-power timer

	bph_sync_t  pins_s;
	logic       pwr_en;
	logic       flow_in_n;
	logic       device_wake_request;
	logic       timer_load;
	logic       timer_expired;

	bph_sync u_sync (
		.ref_clk (ref_clk),
		.reset   (reset),
		.pins    ({low_power_clock, uart_flow_ready_in_n, wake_input_pin, radio_power_enable}),
		.pins_s  (pins_s)
	);

	assign pwr_en    = pins_s[`BPH_SYNC_PWR];
	assign flow_in_n = pins_s[`BPH_SYNC_FLOW];
	// Wake input ignored when handshake lines are not in use
	assign device_wake_request = wake_handshake_en
		& pol_map(pins_s[`BPH_SYNC_WAKE], dev_wake_active_high);

	bph_state_e state_r;
	bph_state_e state_nxt;

	bph_lp_timer u_timer (
		.ref_clk  (ref_clk),
		.reset    (reset),
		.lpc_s    (pins_s[`BPH_SYNC_LPC]),
		.load     (timer_load),
		.active   (state_r == ST_LOWPOW),
		.interval (lp_interval),
		.expired  (timer_expired)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state machine

	bph_cnt_t cnt_r;
	bph_cnt_t cnt_nxt;
	logic     sleep_req;
	logic     wake_req;

	always_comb begin
		sleep_req  = sw_sleep_req | bb_sleep_req;
		wake_req   = sw_wake_req | bb_wake_req;
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		timer_load = 1'h0;
		case (state_r)
			ST_OFF: begin
				if (pwr_en) begin
					state_nxt = ST_CLK_SETTLE;
					cnt_nxt   = bph_cnt_t'(`BPH_CLK_SETTLE_CYC - 1);
				end
			end
			ST_CLK_SETTLE: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = ST_INIT;
					cnt_nxt   = bph_cnt_t'(`BPH_INIT_CYC - 1);
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			ST_INIT: begin
				if (cnt_r == 16'h0000) begin
					state_nxt = ST_LINK_WAIT;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end
			ST_LINK_WAIT: begin
				if (!flow_in_n) begin
					state_nxt = ST_AWAKE;
				end
			end
			ST_AWAKE: begin
				if (device_wake_request) begin
					state_nxt = ST_AWAKE;
				end else if (lp_mode_req) begin
					state_nxt  = ST_LOWPOW;
					timer_load = 1'h1;
				end else if (sleep_req && sleep_criteria_met) begin
					state_nxt = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (device_wake_request || wake_req) begin
					state_nxt = ST_AWAKE;
				end
			end
			ST_LOWPOW: begin
				if (device_wake_request || timer_expired) begin
					state_nxt = ST_AWAKE;
				end
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
		if (!pwr_en) begin
			state_nxt  = ST_OFF;
			cnt_nxt    = 16'h0000;
			timer_load = 1'h0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_r <= ST_OFF;
			cnt_r   <= 16'h0000;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registered pin and RF controls

	logic    io_en_r;
	logic    io_en_nxt;
	logic    host_wake_request;
	logic    host_wake_nxt;
	logic    flow_out_n_r;
	logic    flow_out_n_nxt;
	logic    clk_req_r;
	logic    clk_req_nxt;
	logic    clk_req_oe_r;
	logic    clk_req_oe_nxt;
	bph_rf_t rf_pd_r;
	bph_rf_t rf_pd_nxt;
	logic    por_r;
	logic    por_nxt;
	logic    lp_sel_r;
	logic    lp_sel_nxt;
	logic    awake_r;
	logic    awake_nxt;
	logic    link_up;
	logic    bt_clk_need;

	always_comb begin
		link_up   = (state_nxt == ST_AWAKE) || (state_nxt == ST_SLEEP)
			|| (state_nxt == ST_LOWPOW);
		io_en_nxt = (state_nxt != ST_OFF) && (state_nxt != ST_CLK_SETTLE);
		host_wake_nxt  = io_en_nxt & host_attention_need;
		flow_out_n_nxt = ~link_up;
		bt_clk_need    = host_ref_clk_used && (state_nxt != ST_OFF)
			&& (state_nxt != ST_SLEEP) && (state_nxt != ST_LOWPOW);
		clk_req_nxt    = bt_clk_need | wlan_clk_need;
		clk_req_oe_nxt = (state_nxt != ST_OFF) | wlan_clk_need;
		rf_pd_nxt      = `BPH_RF_PD_ALL;
		if (state_nxt == ST_AWAKE && !sw_rf_off) begin
			rf_pd_nxt[`BPH_RF_TX]  = ~tx_window;
			rf_pd_nxt[`BPH_RF_RX]  = ~rx_window;
			rf_pd_nxt[`BPH_RF_PLL] = ~(tx_window | rx_window);
			rf_pd_nxt[`BPH_RF_PA]  = ~tx_window;
		end
		por_nxt    = (state_nxt == ST_OFF);
		lp_sel_nxt = (state_nxt == ST_LOWPOW);
		awake_nxt  = (state_nxt == ST_AWAKE);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			io_en_r           <= 1'h0;
			host_wake_request <= 1'h0;
			flow_out_n_r      <= 1'h1;
			clk_req_r         <= 1'h0;
			clk_req_oe_r      <= 1'h0;
			rf_pd_r           <= `BPH_RF_PD_ALL;
			por_r             <= 1'h1;
			lp_sel_r          <= 1'h0;
			awake_r           <= 1'h0;
		end else begin
			io_en_r           <= io_en_nxt;
			host_wake_request <= host_wake_nxt;
			flow_out_n_r      <= flow_out_n_nxt;
			clk_req_r         <= clk_req_nxt;
			clk_req_oe_r      <= clk_req_oe_nxt;
			rf_pd_r           <= rf_pd_nxt;
			por_r             <= por_nxt;
			lp_sel_r          <= lp_sel_nxt;
			awake_r           <= awake_nxt;
		end
	end

	assign wake_output_pin        = pol_map(host_wake_request, host_wake_active_high);
	assign wake_output_pin_oe     = io_en_r & wake_handshake_en;
	assign uart_flow_ready_out_n  = flow_out_n_r;
	assign uart_flow_ready_out_oe = io_en_r;
	assign ref_clk_request        = clk_req_r;
	assign ref_clk_request_oe     = clk_req_oe_r;
	assign rf_tx_pd               = rf_pd_r[`BPH_RF_TX];
	assign rf_rx_pd               = rf_pd_r[`BPH_RF_RX];
	assign rf_pll_pd              = rf_pd_r[`BPH_RF_PLL];
	assign rf_pa_pd               = rf_pd_r[`BPH_RF_PA];
	assign por_active             = por_r;
	assign lp_clock_select        = lp_sel_r;
	assign core_awake             = awake_r;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence power_up_s;
		state_r == ST_OFF && pwr_en ##1 state_r == ST_CLK_SETTLE;
	endsequence

	sequence settle_done_s;
		state_r == ST_CLK_SETTLE && cnt_r == 16'h0000 && pwr_en;
	endsequence

	sequence host_ready_s;
		state_r == ST_LINK_WAIT && !flow_in_n && pwr_en;
	endsequence

	por_hold_a: assert property (!pwr_en |=> por_active && state_r == ST_OFF)
		else $error("power-on reset not held while power enable low");

	por_release_a: assert property (power_up_s |-> !por_active)
		else $error("power-on reset not released after power enable rose");

	wake_blocks_a: assert property (state_r == ST_AWAKE && device_wake_request
		&& pwr_en |=> state_r == ST_AWAKE)
		else $error("device left awake state while wake request asserted");

	sleep_wake_a: assert property (state_r == ST_SLEEP && device_wake_request
		&& pwr_en |=> state_r == ST_AWAKE && core_awake)
		else $error("device did not wake on wake request");

	sleep_gate_a: assert property ($rose(state_r == ST_SLEEP)
		|-> $past(sleep_criteria_met && !device_wake_request && sleep_req))
		else $error("sleep entered without criteria");

	host_wake_a: assert property ((io_en_r && pwr_en && state_r != ST_CLK_SETTLE
		&& host_attention_need) |=> wake_output_pin == host_wake_active_high)
		else $error("host wake pin not asserted at selected level");

	clk_req_rise_a: assert property ((state_r == ST_OFF && pwr_en && host_ref_clk_used
		&& $stable(host_ref_clk_used)) |=> ref_clk_request)
		else $error("reference clock request did not rise after power enable");

	wlan_clk_a: assert property (wlan_clk_need |=> ref_clk_request && ref_clk_request_oe)
		else $error("reference clock request low while WLAN needs clock");

	io_settle_a: assert property ($rose(uart_flow_ready_out_oe)
		|-> $past(state_r == ST_CLK_SETTLE && cnt_r == 16'h0000))
		else $error("I/O enabled before clock settling elapsed");

	settle_len_a: assert property (power_up_s
		##1 (state_r == ST_CLK_SETTLE && pwr_en)[*8] |-> !uart_flow_ready_out_oe)
		else $error("I/O enabled early in clock settling");

	flow_resp_a: assert property (host_ready_s |=> !uart_flow_ready_out_n)
		else $error("flow ready not driven low after host and init");

	flow_hold_a: assert property ((state_r == ST_LINK_WAIT && flow_in_n)
		|-> uart_flow_ready_out_n)
		else $error("flow ready low before host flow ready");

	rf_window_a: assert property ((state_r == ST_AWAKE && state_nxt == ST_AWAKE
		&& !sw_rf_off && tx_window && !rx_window)
		|=> !rf_tx_pd && !rf_pa_pd && !rf_pll_pd && rf_rx_pd)
		else $error("RF controls do not follow packet window");

	rf_idle_a: assert property ((state_r == ST_SLEEP || state_r == ST_LOWPOW)
		|-> rf_tx_pd && rf_rx_pd && rf_pll_pd && rf_pa_pd)
		else $error("RF powered outside awake state");

	lp_timer_a: assert property ((state_r == ST_LOWPOW && timer_expired && pwr_en)
		|=> state_r == ST_AWAKE && !lp_clock_select)
		else $error("low-power interval expiry did not wake device");

	lp_dev_wake_a: assert property (state_r == ST_LOWPOW && device_wake_request
		&& pwr_en |=> state_r == ST_AWAKE)
		else $error("wake request did not end low-power mode");

	shutdown_tri_a: assert property ((state_r == ST_OFF && !wlan_clk_need
		&& !$past(wlan_clk_need))
		|-> !wake_output_pin_oe && !uart_flow_ready_out_oe && !ref_clk_request_oe)
		else $error("output driven during shutdown");

	fresh_start_a: assert property ((state_r == ST_OFF && !pwr_en)
		|=> !wake_output_pin_oe && uart_flow_ready_out_n && cnt_r == 16'h0000 && !lp_clock_select)
		else $error("state retained through shutdown");

	handshake_off_a: assert property (!wake_handshake_en
		|-> !wake_output_pin_oe && !device_wake_request)
		else $error("wake handshake active while disabled");
endmodule
`default_nettype wire

// ---- sim/bph_host_model.sv ----
// Host processor model driving power enable, wake request, flow ready and low-power clock
`default_nettype none
module bph_host_model #(
	parameter int SETTLE_CYC = 4,
	parameter int LPC_HALF   = 4
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic power_cmd,
	input  wire logic wake_cmd,
	input  wire logic flow_cmd,
	input  wire logic dev_wake_active_high,
	input  wire logic host_wake_active_high,
	input  wire logic wake_output_pin,
	input  wire logic wake_output_pin_oe,
	output var  logic radio_power_enable,
	output var  logic wake_input_pin,
	output var  logic uart_flow_ready_in_n,
	output var  logic low_power_clock,
	output var  logic host_awake
);
	timeunit 1ns;
	timeprecision 1ps;
	int settle_r;
	int lpc_cnt_r;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			settle_r             <= 0;
			lpc_cnt_r            <= 0;
			radio_power_enable   <= 1'b0;
			uart_flow_ready_in_n <= 1'b1;
			low_power_clock      <= 1'b0;
		end else begin
			// Own pins settled first, only then power enable
			if (settle_r < SETTLE_CYC) begin
				settle_r <= settle_r + 1;
			end
			radio_power_enable   <= power_cmd && (settle_r >= SETTLE_CYC);
			uart_flow_ready_in_n <= !(flow_cmd && radio_power_enable);
			lpc_cnt_r            <= (lpc_cnt_r == LPC_HALF - 1) ? 0 : lpc_cnt_r + 1;
			if (lpc_cnt_r == LPC_HALF - 1) begin
				low_power_clock <= !low_power_clock;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		wake_input_pin <= dev_wake_active_high ? wake_cmd : !wake_cmd;
	end

	// Host stays awake while the device asks for attention
	assign host_awake = wake_output_pin_oe && (wake_output_pin == host_wake_active_high);
endmodule
`default_nettype wire

// ---- sim/bph_top_tb_top.sv ----
// Self-checking testbench of the host power handshake block
`default_nettype none
`include "bph_defs.svh"
module bph_top_tb_top;
	import bph_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, reset = 1, power_cmd = 0, wake_cmd = 0, flow_cmd = 0;
	logic wake_handshake_en = 1, dev_wake_active_high = 1, host_wake_active_high = 1;
	logic host_ref_clk_used = 1, wlan_clk_need = 0, sw_sleep_req = 0, sw_wake_req = 0;
	logic bb_sleep_req = 0, bb_wake_req = 0, sleep_criteria_met = 0, host_attention_need = 0;
	logic lp_mode_req = 0, tx_window = 0, rx_window = 0, sw_rf_off = 0;
	bph_cnt_t lp_interval = '0;
	logic radio_power_enable, wake_input_pin, uart_flow_ready_in_n, low_power_clock, host_awake;
	logic wake_output_pin, wake_output_pin_oe, uart_flow_ready_out_n, uart_flow_ready_out_oe;
	logic ref_clk_request, ref_clk_request_oe, rf_tx_pd, rf_rx_pd, rf_pll_pd, rf_pa_pd;
	logic por_active, lp_clock_select, core_awake;
	logic [3:0] mon;
	int mismatches = 0, samples_checked = 0, seed = 61, n;
	logic [2:0] r;
	assign mon = {core_awake, por_active, lp_clock_select, wake_output_pin_oe};

	initial begin
		forever #20 ref_clk = !ref_clk;
	end

	bph_top bph_top_inst (.ref_clk(ref_clk), .reset(reset),
		.radio_power_enable(radio_power_enable), .wake_input_pin(wake_input_pin),
		.uart_flow_ready_in_n(uart_flow_ready_in_n), .low_power_clock(low_power_clock),
		.wake_handshake_en(wake_handshake_en), .dev_wake_active_high(dev_wake_active_high),
		.host_wake_active_high(host_wake_active_high), .host_ref_clk_used(host_ref_clk_used),
		.wlan_clk_need(wlan_clk_need), .sw_sleep_req(sw_sleep_req), .sw_wake_req(sw_wake_req),
		.bb_sleep_req(bb_sleep_req), .bb_wake_req(bb_wake_req),
		.sleep_criteria_met(sleep_criteria_met), .host_attention_need(host_attention_need),
		.lp_mode_req(lp_mode_req), .lp_interval(lp_interval), .tx_window(tx_window),
		.rx_window(rx_window), .sw_rf_off(sw_rf_off), .wake_output_pin(wake_output_pin),
		.wake_output_pin_oe(wake_output_pin_oe), .uart_flow_ready_out_n(uart_flow_ready_out_n),
		.uart_flow_ready_out_oe(uart_flow_ready_out_oe), .ref_clk_request(ref_clk_request),
		.ref_clk_request_oe(ref_clk_request_oe), .rf_tx_pd(rf_tx_pd), .rf_rx_pd(rf_rx_pd),
		.rf_pll_pd(rf_pll_pd), .rf_pa_pd(rf_pa_pd), .por_active(por_active),
		.lp_clock_select(lp_clock_select), .core_awake(core_awake));

	bph_host_model bph_host_model_inst (.ref_clk(ref_clk), .reset(reset), .power_cmd(power_cmd),
		.wake_cmd(wake_cmd), .flow_cmd(flow_cmd), .dev_wake_active_high(dev_wake_active_high),
		.host_wake_active_high(host_wake_active_high), .wake_output_pin(wake_output_pin),
		.wake_output_pin_oe(wake_output_pin_oe), .radio_power_enable(radio_power_enable),
		.wake_input_pin(wake_input_pin), .uart_flow_ready_in_n(uart_flow_ready_in_n),
		.low_power_clock(low_power_clock), .host_awake(host_awake));

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [3:0] exp_rf(input logic tx, input logic rx, input logic off);
		if (off) begin
			return 4'hF;
		end
		return {!tx, !(tx || rx), !rx, !tx};
	endfunction

	function automatic logic exp_host_pin(input logic need, input logic pol);
		return pol ? need : !need;
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic wait_mon(input int idx, input logic val, input int lim, output int cnt);
		cnt = 0;
		while (mon[idx] !== val) begin
			@(negedge ref_clk);
			cnt++;
			if (cnt > lim) begin
				mismatches++;
				$display("[FAIL] %0t wait timed out on monitor %0d", $time, idx);
				complete_run();
			end
		end
	endtask

	task automatic power_up();
		@(posedge ref_clk);
		power_cmd <= 1'b1;
		wait_mon(2, 1'b0, 20, n);
		check({ref_clk_request, ref_clk_request_oe}, {host_ref_clk_used, 1'h1},
			"clock request after enable");
		wait_mon(0, 1'b1, 100, n);
		check(n, `BPH_CLK_SETTLE_CYC, "cycles before pins enabled");
		check(uart_flow_ready_out_oe, 1'h1, "flow ready driven after settling");
		repeat (`BPH_INIT_CYC + 8) @(negedge ref_clk);
		check({core_awake, uart_flow_ready_out_n}, 2'b01, "ready before host");
		@(posedge ref_clk);
		flow_cmd <= 1'b1;
		wait_mon(3, 1'b1, 10, n);
		check(uart_flow_ready_out_n, 1'b0, "ready after host");
		$display("test power_up done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		check({por_active, wake_output_pin_oe, uart_flow_ready_out_oe}, 3'b100, "reset");
		check({rf_pa_pd, rf_pll_pd, rf_rx_pd, rf_tx_pd}, 4'hF, "rf at reset");
		power_up();
		for (int i = 0; i < 24; i++) begin
			r = 3'($random(seed));
			@(posedge ref_clk);
			host_attention_need   <= r[0];
			host_wake_active_high <= (i < 12);
			tx_window             <= r[1];
			rx_window             <= r[2];
			sw_rf_off             <= (i % 7 == 6);
			@(posedge ref_clk);
			@(negedge ref_clk);
			check(wake_output_pin, exp_host_pin(r[0], i < 12), "host wake pin");
			check({rf_pa_pd, rf_pll_pd, rf_rx_pd, rf_tx_pd},
				exp_rf(r[1], r[2], i % 7 == 6), "rf controls");
			check(host_awake, r[0], "host kept awake by host wake");
		end
		@(posedge ref_clk);
		host_ref_clk_used <= 1'h0;
		wlan_clk_need     <= 1'h1;
		wake_handshake_en <= 1'h0;
		repeat (3) @(negedge ref_clk);
		check(ref_clk_request, 1'h1, "clock request for wlan");
		check(wake_output_pin_oe, 1'h0, "host wake driven without handshake");
		@(posedge ref_clk);
		wlan_clk_need     <= 1'h0;
		wake_handshake_en <= 1'h1;
		repeat (2) @(negedge ref_clk);
		check(ref_clk_request, 1'h0, "clock request without need");
		check(wake_output_pin_oe, 1'h1, "host wake pin enabled");
		@(posedge ref_clk);
		host_ref_clk_used <= 1'h1;
		$display("test pins done");
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			dev_wake_active_high <= i[0];
			wake_cmd             <= 1'b1;
			repeat (6) @(posedge ref_clk);
			sw_sleep_req       <= (i == 0);
			bb_sleep_req       <= (i == 1);
			sleep_criteria_met <= 1'b1;
			repeat (8) @(negedge ref_clk);
			check(core_awake, 1'b1, "sleep while wake held");
			@(posedge ref_clk);
			wake_cmd <= 1'b0;
			wait_mon(3, 1'b0, 8, n);
			@(posedge ref_clk);
			sw_sleep_req <= 1'b0;
			bb_sleep_req <= 1'b0;
			wake_cmd     <= 1'b1;
			wait_mon(3, 1'b1, 8, n);
			@(posedge ref_clk);
			wake_cmd     <= 1'b0;
			sw_sleep_req <= (i == 0);
			bb_sleep_req <= (i == 1);
			wait_mon(3, 1'b0, 8, n);
			@(posedge ref_clk);
			sw_sleep_req <= 1'b0;
			bb_sleep_req <= 1'b0;
			sw_wake_req  <= (i == 0);
			bb_wake_req  <= (i == 1);
			wait_mon(3, 1'b1, 8, n);
			@(posedge ref_clk);
			sw_wake_req <= 1'b0;
			bb_wake_req <= 1'b0;
		end
		$display("test sleep done");
		@(posedge ref_clk);
		lp_interval <= 16'h0003;
		lp_mode_req <= 1'b1;
		wait_mon(1, 1'b1, 4, n);
		@(posedge ref_clk);
		lp_mode_req <= 1'h0;
		wait_mon(1, 1'b0, 60, n);
		// Three ticks of an 8-cycle low-power clock, plus sync and exit
		check(n >= 17 && n <= 26, 1'h1, "low-power interval length");
		wait_mon(3, 1'b1, 4, n);
		@(posedge ref_clk);
		lp_interval <= 16'h00FF;
		lp_mode_req <= 1'h1;
		wait_mon(1, 1'h1, 4, n);
		@(posedge ref_clk);
		lp_mode_req <= 1'h0;
		wake_cmd    <= 1'h1;
		wait_mon(1, 1'h0, 8, n);
		check(core_awake, 1'h1, "wake request ends low-power mode");
		@(posedge ref_clk);
		wake_cmd <= 1'h0;
		$display("test low_power done");
		@(posedge ref_clk);
		power_cmd <= 1'b0;
		flow_cmd  <= 1'b0;
		wait_mon(2, 1'b1, 8, n);
		@(negedge ref_clk);
		check({wake_output_pin_oe, uart_flow_ready_out_oe, ref_clk_request_oe}, 3'b000,
			"shutdown outputs");
		check({rf_pa_pd, rf_pll_pd, rf_rx_pd, rf_tx_pd}, 4'hF, "rf in shutdown");
		@(posedge ref_clk);
		host_ref_clk_used <= 1'h0;
		power_up();
		complete_run();
	end
endmodule
`default_nettype wire
